// *** acr_consts.vh ***
// Constants for the comparator control register bank.
// Assumes inclusion by bare name from the design files.
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH

// ---------------------------------------------------------------
// Register indices (byte map) and APB byte addresses
// ---------------------------------------------------------------
`define ACR_IDX_CTRL      8'h00
`define ACR_IDX_MUX       8'h02
`define ACR_IDX_INTEN     8'h06
`define ACR_IDX_STATUS    8'h07
`define ACR_IDX_IRQMASK   8'h08
`define ACR_ADDR_CTRL     12'h000
`define ACR_ADDR_MUX      12'h008
`define ACR_ADDR_INTEN    12'h018
`define ACR_ADDR_STATUS   12'h01c
`define ACR_ADDR_IRQMASK  12'h020

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACR_CTRL_STBYRUN  7
`define ACR_CTRL_PADEN    6
`define ACR_CTRL_EDGE_HI  5
`define ACR_CTRL_EDGE_LO  4
`define ACR_CTRL_HYS_HI   2
`define ACR_CTRL_HYS_LO   1
`define ACR_CTRL_ENABLE   0
`define ACR_MUX_INVERT    7
`define ACR_MUX_POS       3
`define ACR_MUX_NEG_HI    1
`define ACR_MUX_NEG_LO    0
`define ACR_STAT_STATE    4
`define ACR_STAT_FLAG     0

// Writable bit masks; everything else reads as zero
`define ACR_CTRL_WMASK    8'hf7
`define ACR_MUX_WMASK     8'h83
`define ACR_INTEN_WMASK   8'h01
`define ACR_RESET_VALUE   8'h00

// ---------------------------------------------------------------
// Encodings
// ---------------------------------------------------------------
`define ACR_EDGE_ANY      2'h0
`define ACR_EDGE_FALL     2'h2
`define ACR_EDGE_RISE     2'h3
`define ACR_NEG_PIN0      2'h0
`define ACR_NEG_VREF      2'h2
`define ACR_POS_PIN0      1'h0

// Synchroniser depth giving a three-cycle state lag
`define ACR_SYNC_STAGES   3
// Pad and event path synchroniser depth
`define ACR_PAD_SYNC_STAGES 2

`endif

// *** acr_sync.v ***
// Level synchroniser for the asynchronous comparator output.
// Assumes a single clock; first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module acr_sync #(
    parameter STAGES = 3
) (
    // Clock and control
    input  wire clk,
    input  wire reset,
    input  wire ce,
    // Data
    input  wire asyncIn,
    output wire syncOut
);
    reg [STAGES-1:0] chain;

    always @(posedge clk)
    begin
        if (reset)
            chain <= {STAGES{1'b0}};
        else if (ce)
            chain <= {chain[STAGES-2:0], asyncIn};
    end

    assign syncOut = chain[STAGES-1];
endmodule // acr_sync
`default_nettype wire

// *** acr_edge.v ***
// Edge detector choosing which transitions raise the interrupt event.
// Assumes its input is already synchronous to the clock.
`timescale 1ns/1ps
`include "acr_consts.vh"
`default_nettype none
module acr_edge (
    // Clock and control
    input  wire       clk,
    input  wire       reset,
    input  wire       ce,
    input  wire       armed,
    // Data
    input  wire       level,
    input  wire [1:0] edgeSelect,
    output wire       hit
);
    reg  last;
    reg  lastValid;
    wire rise;
    wire fall;

    always @(posedge clk)
    begin
        if (reset)
        begin
            last      <= 1'b0;
            lastValid <= 1'b0;
        end
        else if (ce)
        begin
            last      <= level;
            lastValid <= armed;
        end
    end

    assign rise = armed & lastValid & level & ~last;
    assign fall = armed & lastValid & ~level & last;
    assign hit  = (edgeSelect == `ACR_EDGE_ANY)  ? (rise | fall) :
                  (edgeSelect == `ACR_EDGE_FALL) ? fall :
                  (edgeSelect == `ACR_EDGE_RISE) ? rise : 1'b0;
endmodule // acr_edge
`default_nettype wire

// *** acr_regs.v ***
// Comparator control and status register bank with APB slave.
// Assumes the analog core, pad and event routing sit outside; the
// core output arrives asynchronously and is synchronised here.
`timescale 1ns/1ps
`include "acr_consts.vh"
`default_nettype none

// Operation
// - Standby-run set keeps the comparator running in standby sleep.
// - Standby-run clear halts the whole comparator in standby sleep.
// - Clock stopped in standby: no status update, no flag raised.
// - Pad-output enable routes comparator output to its pin.
// - Edge select picks both, falling or rising edges for the flag.
// - Hysteresis field drives the analog hysteresis setting.
// - Enable bit turns the comparator on; zero keeps it off.
// - Invert bit inverts output for every consumer.
// - Positive select zero picks positive pin zero; one reserved.
// - Negative select picks pin zero or internal reference.
// - Interrupt enable bit gates the comparator request.
// - State bit shows synchronised output, three cycles late.
// - Writing one clears the flag; writing zero leaves it.
// - Request high while flag, enable bit and irqMask bit 0 are set, until cleared.
// - Enabled comparator output goes out as asynchronous event; here registered on core_clk after the two-stage synchroniser.
// - Power-down sleep disables comparator and pad output.
// - Stopped-clock standby: event and pad still follow output.
module acr_regs (
    // Clock and control
    input  wire        core_clk,
    input  wire        reset,
    input  wire        clkEnable,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Sleep state from power manager
    input  wire        standbySleep,
    input  wire        powerDownSleep,
    input  wire        perClockStopped,
    // Analog core
    input  wire        compRaw,
    output reg         compEnable,
    output reg  [1:0]  hysteresisSelect,
    output reg         positiveInputSelect,
    output reg  [1:0]  negativeInputSelect,
    // Pad, event and interrupt
    output reg         padOut,
    output reg         padOutEnable,
    output reg         eventOut,
    output reg         irq
);
    // -----------------------------------------------------------
    // Register state
    // -----------------------------------------------------------
    reg  [7:0] comparatorControl;
    reg  [7:0] inputSelectControl;
    reg  [7:0] interruptEnable;
    reg  [7:0] irqMask;
    reg        flag;
    reg  [7:0] rdata;
    reg        next_flag;
    reg  [7:0] next_ctrl;
    reg  [7:0] next_mux;
    reg  [7:0] next_inten;
    reg  [7:0] next_mask;

    wire       stbyRun   = comparatorControl[`ACR_CTRL_STBYRUN];
    wire       enableBit = comparatorControl[`ACR_CTRL_ENABLE];
    wire       invertBit = inputSelectControl[`ACR_MUX_INVERT];
    wire [1:0] edgeSel   = comparatorControl[`ACR_CTRL_EDGE_HI:
                                             `ACR_CTRL_EDGE_LO];

    // -----------------------------------------------------------
    // Operating condition
    // -----------------------------------------------------------
    // Comparator runs when enabled, not powered down, and standby
    // either absent or allowed.
    wire running = enableBit & ~powerDownSleep
                 & (~standbySleep | stbyRun);
    // Status logic halted while the peripheral clock is stopped in standby.
    wire statusLive = clkEnable & ~(standbySleep & perClockStopped);

    // -----------------------------------------------------------
    // APB decode
    // -----------------------------------------------------------
    wire access   = psel & penable;
    wire doWrite  = access & pwrite & pready;
    wire hitCtrl  = (paddr == `ACR_ADDR_CTRL);
    wire hitMux   = (paddr == `ACR_ADDR_MUX);
    wire hitInten = (paddr == `ACR_ADDR_INTEN);
    wire hitStat  = (paddr == `ACR_ADDR_STATUS);
    wire hitMask  = (paddr == `ACR_ADDR_IRQMASK);
    wire mapped   = hitCtrl | hitMux | hitInten | hitStat | hitMask;

    function [7:0] wmask;
        input [7:0] value;
        input [7:0] mask;
        begin
            wmask = value & mask;
        end
    endfunction

    // -----------------------------------------------------------
    // Synchronise and condition the comparator output
    // -----------------------------------------------------------
    wire compSyncRaw;
    wire compSync;
    wire padSyncRaw;
    wire padLevel;

    acr_sync #(
        .STAGES  (`ACR_SYNC_STAGES)
    ) uSync (
        .clk     (core_clk),
        .reset   (reset),
        .ce      (statusLive),
        .asyncIn (compRaw),
        .syncOut (compSyncRaw)
    );

    // Inversion after the flops: no logic reads the raw pin
    assign compSync = compSyncRaw ^ invertBit;

    // Pad and event path keeps running while status is frozen
    acr_sync #(
        .STAGES  (`ACR_PAD_SYNC_STAGES)
    ) uPadSync (
        .clk     (core_clk),
        .reset   (reset),
        .ce      (clkEnable),
        .asyncIn (compRaw),
        .syncOut (padSyncRaw)
    );

    assign padLevel = padSyncRaw ^ invertBit;

    wire edgeHit;

    acr_edge uEdge (
        .clk        (core_clk),
        .reset      (reset),
        .ce         (statusLive),
        .armed      (running),
        .level      (compSync),
        .edgeSelect (edgeSel),
        .hit        (edgeHit)
    );

    // -----------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------
    always @*
    begin
        next_ctrl = comparatorControl;
        next_mux  = inputSelectControl;
        next_flag = flag;
        next_inten = interruptEnable;
        next_mask  = irqMask;
        if (doWrite && hitInten)
            next_inten = wmask(pwdata[7:0], `ACR_INTEN_WMASK);
        if (doWrite && hitMask)
            next_mask = wmask(pwdata[7:0], `ACR_INTEN_WMASK);
        if (doWrite && hitCtrl)
            next_ctrl = wmask(pwdata[7:0], `ACR_CTRL_WMASK);
        if (doWrite && hitMux)
            next_mux = wmask(pwdata[7:0], `ACR_MUX_WMASK);
        if (doWrite && hitStat && pwdata[`ACR_STAT_FLAG])
            next_flag = 1'b0;
        // Set wins over a simultaneous clear
        if (edgeHit && statusLive)
            next_flag = 1'b1;
    end

    always @*
    begin
        rdata = 8'h00;
        if (hitCtrl)
            rdata = comparatorControl;
        else if (hitMux)
            rdata = inputSelectControl;
        else if (hitInten)
            rdata = interruptEnable;
        else if (hitStat)
            rdata = {3'h0, compSync, 3'h0, flag};
        else if (hitMask)
            rdata = irqMask;
    end

    // -----------------------------------------------------------
    // Registers and APB answer
    // -----------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            comparatorControl  <= `ACR_RESET_VALUE;
            inputSelectControl <= `ACR_RESET_VALUE;
            interruptEnable    <= `ACR_RESET_VALUE;
            irqMask            <= `ACR_RESET_VALUE;
            flag               <= 1'b0;
            prdata             <= 32'h0000_0000;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
        end
        else if (clkEnable)
        begin
            comparatorControl  <= next_ctrl;
            inputSelectControl <= next_mux;
            flag               <= next_flag;
            interruptEnable    <= next_inten;
            irqMask            <= next_mask;
            // One wait state: ready in the second access cycle
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access && !pready && !pwrite)
                prdata <= {24'h00_0000, rdata};
        end
    end

    // -----------------------------------------------------------
    // Outputs to core, pad, event system and interrupt
    // -----------------------------------------------------------
    // These are registered on core_clk while clkEnable is high, so during a
    // stopped-clock standby they keep updating: pad and event follow the short
    // synchroniser, while no edge sets the flag, so irq moves only on APB writes.
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            compEnable          <= 1'b0;
            hysteresisSelect    <= 2'h0;
            positiveInputSelect <= `ACR_POS_PIN0;
            negativeInputSelect <= `ACR_NEG_PIN0;
            padOut              <= 1'b0;
            padOutEnable        <= 1'b0;
            eventOut            <= 1'b0;
            irq                 <= 1'b0;
        end
        else if (clkEnable)
        begin
            compEnable       <= running;
            hysteresisSelect <= next_ctrl[`ACR_CTRL_HYS_HI:
                                          `ACR_CTRL_HYS_LO];
            positiveInputSelect <= next_mux[`ACR_MUX_POS];
            negativeInputSelect <= next_mux[`ACR_MUX_NEG_HI:
                                            `ACR_MUX_NEG_LO];
            padOutEnable <= running
                          & comparatorControl[`ACR_CTRL_PADEN];
            // Short synchroniser, not frozen by a stopped status clock
            padOut   <= running & padLevel;
            eventOut <= running & padLevel;
            irq      <= next_flag & next_inten[0]
                      & next_mask[0];
        end
    end
endmodule // acr_regs
`default_nettype wire

// *** acr_comp_model.sv ***
// Behavioural model of the analog comparator core.
// Assumes the bench sets both compare results as plain levels.
`timescale 1ns/1ps
`include "acr_consts.vh"
`default_nettype none
module acr_comp_model (
    // Control from the register bank
    input  wire logic       compEnable,
    input  wire logic [1:0] negativeInputSelect,
    // Compare results per negative source
    input  wire logic       levelPin,
    input  wire logic       levelRef,
    // Output
    output var  logic       compRaw
);
    // Off core drives low; mux picks pin or reference
    always_comb
    begin
        compRaw = 1'b0;
        if (compEnable)
            compRaw = (negativeInputSelect == `ACR_NEG_VREF) ? levelRef
                                                             : levelPin;
    end
endmodule // acr_comp_model
`default_nettype wire

// *** acr_regs_checker.sv ***
// Assertions on the ports of the comparator register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module acr_regs_checker (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        clkEnable,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        standbySleep,
    input wire logic        powerDownSleep,
    input wire logic        perClockStopped,
    input wire logic        compEnable,
    input wire logic [1:0]  hysteresisSelect,
    input wire logic        padOutEnable,
    input wire logic        eventOut,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic idle = clkEnable && !psel;
    a_ready_pulse: assert property (pready && clkEnable |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_answer: assert property (psel && penable && !pready && clkEnable
        |=> pready) else $error("access not answered");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_powerdown_off: assert property (powerDownSleep && clkEnable
        |=> !compEnable && !padOutEnable) else $error("on in power-down");
    a_event_enable: assert property (eventOut |-> compEnable)
        else $error("event while comparator off");
    a_irq_hold: assert property (irq && idle |=> irq)
        else $error("irq dropped without write");
    a_stopped_freeze: assert property ((standbySleep && perClockStopped
        && idle)[*2] |-> $stable(irq)) else $error("irq moved");
    a_hys_stable: assert property (idle |=> $stable(hysteresisSelect))
        else $error("hysteresis moved without write");
    c_irq: cover property (!irq ##1 irq);
    c_err: cover property (pslverr);
    c_pd: cover property (powerDownSleep && compEnable);
endmodule // acr_regs_checker
bind acr_regs acr_regs_checker i_acr_regs_checker (.core_clk, .reset,
    .clkEnable, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .standbySleep, .powerDownSleep, .perClockStopped, .compEnable,
    .hysteresisSelect, .padOutEnable, .eventOut, .irq);
`default_nettype wire

// *** comparator_control_regs_bench.sv ***
// Self-checking bench for the comparator register bank.
// Assumes acr_regs, its checker and the analog core model.
`timescale 1ns/1ps
`include "acr_consts.vh"
`default_nettype none
module comparator_control_regs_bench;
    logic        core_clk = 0, reset = 1, clkEnable = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, compRaw, compEnable, padOut;
    logic        sb = 0, pd = 0, stop = 0, lvP = 0, lvR = 0;
    logic        padOutEnable, eventOut, irq, posSel;
    logic [1:0]  hysSel, negSel;
    logic [7:0]  rd;
    logic        er;
    int          err_count = 0, n_checks = 0;
    always #2.5 core_clk = ~core_clk;
    acr_regs i_acr_regs (.core_clk, .reset, .clkEnable, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .standbySleep(sb), .powerDownSleep(pd), .perClockStopped(stop),
        .compRaw, .compEnable, .hysteresisSelect(hysSel),
        .positiveInputSelect(posSel), .negativeInputSelect(negSel), .padOut,
        .padOutEnable, .eventOut, .irq);
    acr_comp_model i_acr_comp_model (.compEnable, .compRaw,
        .negativeInputSelect(negSel), .levelPin(lvP), .levelRef(lvR));
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 20)
        begin
            chk(8'h0, 8'h1);
            final_report();
        end
        @(posedge core_clk);
    endtask
    task automatic t_reset_map;
        apb(0, `ACR_ADDR_CTRL, 0);   chk(rd, 8'h00);
        apb(0, `ACR_ADDR_STATUS, 0); chk(rd, 8'h00);
        apb(1, 12'h010, 8'hff);      chk({7'h0, er}, 8'h1);
        apb(0, 12'h010, 0);          chk(rd, 8'h00);
        apb(1, `ACR_ADDR_CTRL, 8'h7f); chk({7'h0, er}, 8'h0);
        apb(0, `ACR_ADDR_CTRL, 0);   chk(rd, 8'h77);
        chk({hysSel, padOutEnable, compEnable}, 8'hf);
        apb(1, `ACR_ADDR_MUX, 8'hff); apb(0, `ACR_ADDR_MUX, 0);
        chk(rd, 8'h83);
        chk({posSel, negSel}, 8'h3);
        $display("test reset_map done");
    endtask
    // Each edge mode, flag, enable gating and write-one clear
    task automatic t_edges;
        logic [1:0] m[3] = '{2'h0, 2'h2, 2'h3};
        apb(1, `ACR_ADDR_MUX, 8'h00); apb(1, `ACR_ADDR_IRQMASK, 8'h01);
        apb(1, `ACR_ADDR_STATUS, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            apb(1, `ACR_ADDR_CTRL, {2'h0, m[i], 4'h1});
            apb(1, `ACR_ADDR_INTEN, 8'h01);
            lvP <= 1; wc(8);
            chk({7'h0, irq}, {7'h0, m[i] != 2'h2});
            apb(1, `ACR_ADDR_STATUS, 8'h01); wc(2);
            chk({7'h0, irq}, 8'h0);
            lvP <= 0; wc(8);
            chk({7'h0, irq}, {7'h0, m[i] != 2'h3});
            apb(1, `ACR_ADDR_STATUS, 8'h00); wc(2);
            chk({7'h0, irq}, {7'h0, m[i] != 2'h3});
            apb(1, `ACR_ADDR_INTEN, 8'h00);
            chk({7'h0, irq}, 8'h0);
            apb(1, `ACR_ADDR_STATUS, 8'h01);
        end
        $display("test edges done");
    endtask
    task automatic t_state;
        apb(1, `ACR_ADDR_CTRL, 8'h01); lvP <= 1; wc(5);
        apb(0, `ACR_ADDR_STATUS, 0); chk(rd & 8'h10, 8'h10);
        apb(1, `ACR_ADDR_MUX, 8'h80); wc(5);
        apb(0, `ACR_ADDR_STATUS, 0); chk(rd & 8'h10, 8'h00);
        apb(1, `ACR_ADDR_MUX, 8'h02); lvP <= 0; lvR <= 1; wc(5);
        apb(0, `ACR_ADDR_STATUS, 0); chk(rd & 8'h10, 8'h10);
        $display("test state done");
    endtask
    task automatic t_sleep;
        apb(1, `ACR_ADDR_MUX, 8'h00); apb(1, `ACR_ADDR_CTRL, 8'h41);
        sb <= 1; wc(3);
        chk({7'h0, compEnable}, 8'h0);
        apb(1, `ACR_ADDR_STATUS, 8'h01); apb(1, `ACR_ADDR_INTEN, 8'h01);
        apb(1, `ACR_ADDR_CTRL, 8'hc1); stop <= 1; lvP <= 0; wc(3);
        chk({compEnable, padOutEnable, padOut, eventOut}, 8'hc);
        lvP <= 1; wc(4);
        chk({padOut, eventOut, irq}, 8'h6);
        pd <= 1; wc(3);
        chk({compEnable, padOutEnable}, 8'h0);
        pd <= 0; sb <= 0; stop <= 0; wc(2);
        $display("test sleep done");
    endtask
    initial
    begin
        wc(5);
        reset <= 0;
        @(posedge core_clk);
        t_reset_map();
        t_edges();
        t_state();
        t_sleep();
        final_report();
    end
endmodule // comparator_control_regs_bench
`default_nettype wire
